/* File: rtl/trig_pkg.sv */
// Shared constants and types for the exposure start trigger controller and its host end.
`default_nettype none
package trig_pkg;
  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_DIV_W = 8;
  localparam int TIME_W = 26;
  localparam int FCNT_W = 16;
  localparam int READOUT_US_DEF = 100;

  // ******************************************************************
  // Trigger source codes
  // ******************************************************************
  localparam logic [4:0] SRC_SOFTWARE = 5'h03;
  localparam logic [4:0] SRC_HOST_OUT = 5'h0a;
  localparam logic [4:0] SRC_CC1 = 5'h0e;
  localparam logic [4:0] SRC_DELAYED = 5'h12;
  localparam logic [4:0] SRC_HW_LINE = 5'h16;

  // Indices of the synchronised external inputs.
  localparam int IN_HW = 0;
  localparam int IN_CC1 = 1;
  localparam int IN_HOST = 2;

  // ******************************************************************
  // Register map of the host end
  // ******************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_EXPOSURE = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0c;
  localparam logic [7:0] ADDR_TDELAY = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_ACT_BIT = 1;
  localparam int CTRL_EMODE_BIT = 2;
  localparam int CTRL_HOST_OUT_BIT = 3;
  localparam int CTRL_CC1_BIT = 4;
  localparam int CTRL_SRC_LSB = 8;
  localparam int CTRL_TSRC_LSB = 16;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_SWTRIG_BIT = 2;
  localparam int STAT_ACQ_BIT = 0;
  localparam int STAT_WAIT_BIT = 1;
  localparam int STAT_EXP_BIT = 2;
  localparam int STAT_FCNT_LSB = 16;

  localparam logic [TIME_W-1:0] EXPOSURE_RST = 26'h00003e8;
  localparam logic [TIME_W-1:0] PERIOD_RST = 26'h0002710;
  localparam logic [TIME_W-1:0] TDELAY_RST = 26'h0000000;

  // ******************************************************************
  // Frame state
  // ******************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_EXPOSE = 2'b10,
    ST_READOUT = 2'b11
  } frame_state_t;
endpackage : trig_pkg
`default_nettype wire

/* File: rtl/trig_link_if.sv */
// Link between the host end and the camera trigger controller.
`default_nettype none
interface trig_link_if;
  logic acq_start;
  logic acq_stop;
  logic sw_trigger;
  logic trigger_mode;
  logic [4:0] trigger_source;
  logic [4:0] timer_trigger_source;
  logic trigger_activation;
  logic exposure_mode;
  logic [trig_pkg::TIME_W-1:0] exposure_us;
  logic [trig_pkg::TIME_W-1:0] frame_period_us;
  logic [trig_pkg::TIME_W-1:0] timer_delay_us;
  logic host_toggled_output_source;
  logic cc1;
  logic acquiring;
  logic waiting;
  logic exposing;
  logic [trig_pkg::FCNT_W-1:0] frame_count;

  modport dev (
    input acq_start, acq_stop, sw_trigger, trigger_mode, trigger_source,
    input timer_trigger_source, trigger_activation, exposure_mode, exposure_us,
    input frame_period_us, timer_delay_us, host_toggled_output_source, cc1,
    output acquiring, waiting, exposing, frame_count
  );
  modport ctl (
    output acq_start, acq_stop, sw_trigger, trigger_mode, trigger_source,
    output timer_trigger_source, trigger_activation, exposure_mode, exposure_us,
    output frame_period_us, timer_delay_us, host_toggled_output_source, cc1,
    input acquiring, waiting, exposing, frame_count
  );
endinterface : trig_link_if
`default_nettype wire

/* File: rtl/exposure_start_trigger_ctrl.sv */
// Camera end: exposure start trigger generation, selection and exposure timing.
`default_nettype none
module exposure_start_trigger_ctrl #(
  parameter int READOUT_US = trig_pkg::READOUT_US_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hardware_trigger_input,
  output logic frame_start,
  output logic exposure_active,
  trig_link_if.dev link
);
  // Refuse a readout span or a tick divider that the counters cannot hold.
  if (READOUT_US < 1 || READOUT_US >= (1 << (trig_pkg::TIME_W - 1)) ||
      trig_pkg::US_CYCLES > (1 << trig_pkg::US_DIV_W)) begin : g_bad_readout
    $error("READOUT_US out of range");
  end

  localparam logic [trig_pkg::TIME_W-1:0] READOUT_T = trig_pkg::TIME_W'(READOUT_US);
  localparam logic [trig_pkg::US_DIV_W-1:0] US_LAST = trig_pkg::US_DIV_W'(trig_pkg::US_CYCLES - 1);

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    logic [2:0][2:0] sync;
    logic [2:0] filt;
    trig_pkg::frame_state_t state;
    logic stop_pend;
    logic mode;
    logic [4:0] src;
    logic [4:0] tsrc;
    logic act;
    logic emode;
    logic [trig_pkg::US_DIV_W-1:0] us_div;
    logic [trig_pkg::TIME_W-1:0] exp_cnt;
    logic [trig_pkg::TIME_W-1:0] rd_cnt;
    logic [trig_pkg::TIME_W-1:0] fr_cnt;
    logic [trig_pkg::TIME_W-1:0] tmr_cnt;
    logic tmr_run;
    logic acquiring;
    logic waiting;
    logic exposing;
    logic frame_start;
    logic [trig_pkg::FCNT_W-1:0] frame_count;
  } st_t;

  st_t r_reg;
  st_t r_next;

  // Shortest frame the sensor can serve: exposure followed by readout.
  function automatic logic [trig_pkg::TIME_W-1:0] min_frame_us(
    input logic [trig_pkg::TIME_W-1:0] exp_us
  );
    min_frame_us = exp_us + READOUT_T;
  endfunction : min_frame_us

  function automatic logic [trig_pkg::TIME_W-1:0] at_least_one(
    input logic [trig_pkg::TIME_W-1:0] v
  );
    at_least_one = (v == '0) ? trig_pkg::TIME_W'(1) : v;
  endfunction : at_least_one

  logic [2:0] ext_in;
  logic [2:0] edge_hit;
  logic [2:0] active_lvl;
  logic us_tick;
  logic trig;
  logic width_exp;
  logic sel_active;
  logic [trig_pkg::TIME_W-1:0] limit_us;
  logic [trig_pkg::TIME_W-1:0] period_eff;

  assign ext_in[trig_pkg::IN_HW] = hardware_trigger_input;
  assign ext_in[trig_pkg::IN_CC1] = link.cc1;
  assign ext_in[trig_pkg::IN_HOST] = link.host_toggled_output_source;

  always_comb begin
    r_next = r_reg;
    r_next.frame_start = 1'b0;
    // ******************************************************************
    // Input synchronisers and edge detection
    // ******************************************************************
    for (int i = 0; i < 3; i++) begin
      r_next.sync[i] = {r_reg.sync[i][1:0], ext_in[i]};
      if (r_reg.sync[i][1] == r_reg.sync[i][2]) begin
        r_next.filt[i] = r_reg.sync[i][2];
      end
      edge_hit[i] = (r_next.filt[i] != r_reg.filt[i]) && (r_next.filt[i] == r_reg.act);
      active_lvl[i] = (r_reg.filt[i] == r_reg.act);
    end

    // ******************************************************************
    // Microsecond tick, restarted where a timed span begins
    // ******************************************************************
    us_tick = (r_reg.us_div == US_LAST);
    r_next.us_div = us_tick ? '0 : r_reg.us_div + 1'b1;

    limit_us = min_frame_us(at_least_one(link.exposure_us));
    period_eff = (link.frame_period_us > limit_us) ? link.frame_period_us : limit_us;

    // ******************************************************************
    // Delay timer on the hardware line
    // ******************************************************************
    if (r_reg.tmr_run) begin
      if (r_reg.tmr_cnt != '0 && us_tick) begin
        r_next.tmr_cnt = r_reg.tmr_cnt - 1'b1;
      end
    end else if (r_reg.state == trig_pkg::ST_WAIT && r_reg.src == trig_pkg::SRC_DELAYED &&
                 r_reg.tsrc == trig_pkg::SRC_HW_LINE && edge_hit[trig_pkg::IN_HW]) begin
      r_next.tmr_run = 1'b1;
      r_next.tmr_cnt = link.timer_delay_us;
      r_next.us_div = '0;
    end

    // ******************************************************************
    // Trigger selection
    // ******************************************************************
    trig = 1'b0;
    sel_active = 1'b0;
    if (!r_reg.mode) begin
      // Firing in the last cycle of the period keeps the spacing exact.
      trig = (r_reg.fr_cnt == '0) ||
             (r_reg.fr_cnt == trig_pkg::TIME_W'(1) && us_tick);
    end else begin
      unique case (r_reg.src)
        trig_pkg::SRC_SOFTWARE: trig = link.sw_trigger;
        trig_pkg::SRC_HOST_OUT: begin
          trig = edge_hit[trig_pkg::IN_HOST];
          sel_active = active_lvl[trig_pkg::IN_HOST];
        end
        trig_pkg::SRC_CC1: begin
          trig = edge_hit[trig_pkg::IN_CC1];
          sel_active = active_lvl[trig_pkg::IN_CC1];
        end
        trig_pkg::SRC_HW_LINE: begin
          trig = edge_hit[trig_pkg::IN_HW];
          sel_active = active_lvl[trig_pkg::IN_HW];
        end
        trig_pkg::SRC_DELAYED: trig = r_reg.tmr_run && r_reg.tmr_cnt == '0;
        default: trig = 1'b0;
      endcase
    end
    width_exp = r_reg.mode && r_reg.emode && (r_reg.src == trig_pkg::SRC_HOST_OUT ||
                r_reg.src == trig_pkg::SRC_CC1 || r_reg.src == trig_pkg::SRC_HW_LINE);

    if (r_reg.fr_cnt != '0 && us_tick) begin
      r_next.fr_cnt = r_reg.fr_cnt - 1'b1;
    end

    // ******************************************************************
    // Frame sequencing
    // ******************************************************************
    unique case (r_reg.state)
      trig_pkg::ST_IDLE: begin
        if (link.acq_start) begin
          r_next.state = trig_pkg::ST_WAIT;
          r_next.mode = link.trigger_mode;
          r_next.src = link.trigger_source;
          r_next.tsrc = link.timer_trigger_source;
          r_next.act = link.trigger_activation;
          r_next.emode = link.exposure_mode;
          r_next.fr_cnt = '0;
          r_next.tmr_run = 1'b0;
          r_next.stop_pend = 1'b0;
        end
      end
      trig_pkg::ST_WAIT: begin
        if (link.acq_stop) begin
          r_next.state = trig_pkg::ST_IDLE;
          r_next.tmr_run = 1'b0;
        end else if (trig) begin
          r_next.state = trig_pkg::ST_EXPOSE;
          r_next.frame_start = 1'b1;
          r_next.frame_count = r_reg.frame_count + 1'b1;
          r_next.exp_cnt = at_least_one(link.exposure_us);
          r_next.us_div = '0;
          r_next.fr_cnt = period_eff;
          r_next.tmr_run = 1'b0;
        end
      end
      trig_pkg::ST_EXPOSE: begin
        if (link.acq_stop) begin
          r_next.stop_pend = 1'b1;
        end
        if (width_exp ? !sel_active : (us_tick && r_reg.exp_cnt == trig_pkg::TIME_W'(1))) begin
          r_next.state = trig_pkg::ST_READOUT;
          r_next.rd_cnt = READOUT_T;
          r_next.us_div = '0;
        end else if (!width_exp && us_tick) begin
          r_next.exp_cnt = r_reg.exp_cnt - 1'b1;
        end
      end
      trig_pkg::ST_READOUT: begin
        if (link.acq_stop) begin
          r_next.stop_pend = 1'b1;
        end
        if (us_tick) begin
          r_next.rd_cnt = r_reg.rd_cnt - 1'b1;
          if (r_reg.rd_cnt == trig_pkg::TIME_W'(1)) begin
            r_next.state = (r_reg.stop_pend || link.acq_stop) ?
                           trig_pkg::ST_IDLE : trig_pkg::ST_WAIT;
            r_next.stop_pend = 1'b0;
          end
        end
      end
    endcase
    // Edges seen outside the waiting state are simply not acted upon.

    r_next.acquiring = (r_next.state != trig_pkg::ST_IDLE);
    r_next.waiting = (r_next.state == trig_pkg::ST_WAIT);
    r_next.exposing = (r_next.state == trig_pkg::ST_EXPOSE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '{state: trig_pkg::ST_IDLE, src: trig_pkg::SRC_SOFTWARE,
                 tsrc: trig_pkg::SRC_HW_LINE, act: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign frame_start = r_reg.frame_start;
  assign exposure_active = r_reg.exposing;
  assign link.acquiring = r_reg.acquiring;
  assign link.waiting = r_reg.waiting;
  assign link.exposing = r_reg.exposing;
  assign link.frame_count = r_reg.frame_count;
endmodule : exposure_start_trigger_ctrl
`default_nettype wire

/* File: rtl/trigger_host_ctrl.sv */
// Host end: AHB-Lite register file that drives the trigger link.
`default_nettype none
module trigger_host_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  trig_link_if.ctl link
);
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic mode;
    logic act;
    logic emode;
    logic host_out;
    logic cc1;
    logic [4:0] src;
    logic [4:0] tsrc;
    logic [trig_pkg::TIME_W-1:0] exposure;
    logic [trig_pkg::TIME_W-1:0] period;
    logic [trig_pkg::TIME_W-1:0] tdelay;
    logic start;
    logic stop;
    logic swtrig;
  } hst_t;

  hst_t r_reg;
  hst_t r_next;
  logic take;

  always_comb begin
    r_next = r_reg;
    r_next.start = 1'b0;
    r_next.stop = 1'b0;
    r_next.swtrig = 1'b0;
    take = hsel && hready && htrans[1];
    r_next.wr_pend = take && hwrite;
    if (take) begin
      r_next.wr_addr = haddr[7:0];
    end
    // ******************************************************************
    // Read data, presented in the data phase
    // ******************************************************************
    r_next.rdata = '0;
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        trig_pkg::ADDR_CTRL: begin
          r_next.rdata[trig_pkg::CTRL_MODE_BIT] = r_reg.mode;
          r_next.rdata[trig_pkg::CTRL_ACT_BIT] = r_reg.act;
          r_next.rdata[trig_pkg::CTRL_EMODE_BIT] = r_reg.emode;
          r_next.rdata[trig_pkg::CTRL_HOST_OUT_BIT] = r_reg.host_out;
          r_next.rdata[trig_pkg::CTRL_CC1_BIT] = r_reg.cc1;
          r_next.rdata[trig_pkg::CTRL_SRC_LSB +: 5] = r_reg.src;
          r_next.rdata[trig_pkg::CTRL_TSRC_LSB +: 5] = r_reg.tsrc;
        end
        trig_pkg::ADDR_EXPOSURE: r_next.rdata[trig_pkg::TIME_W-1:0] = r_reg.exposure;
        trig_pkg::ADDR_PERIOD: r_next.rdata[trig_pkg::TIME_W-1:0] = r_reg.period;
        trig_pkg::ADDR_TDELAY: r_next.rdata[trig_pkg::TIME_W-1:0] = r_reg.tdelay;
        trig_pkg::ADDR_STATUS: begin
          r_next.rdata[trig_pkg::STAT_ACQ_BIT] = link.acquiring;
          r_next.rdata[trig_pkg::STAT_WAIT_BIT] = link.waiting;
          r_next.rdata[trig_pkg::STAT_EXP_BIT] = link.exposing;
          r_next.rdata[trig_pkg::STAT_FCNT_LSB +: trig_pkg::FCNT_W] = link.frame_count;
        end
        default: r_next.rdata = '0;
      endcase
    end
    // ******************************************************************
    // Writes, taken in the data phase
    // ******************************************************************
    if (r_reg.wr_pend) begin
      unique case (r_reg.wr_addr)
        trig_pkg::ADDR_CTRL: begin
          if (!link.acquiring) begin
            r_next.mode = hwdata[trig_pkg::CTRL_MODE_BIT];
          end
          r_next.act = hwdata[trig_pkg::CTRL_ACT_BIT];
          r_next.emode = hwdata[trig_pkg::CTRL_EMODE_BIT];
          r_next.host_out = hwdata[trig_pkg::CTRL_HOST_OUT_BIT];
          r_next.cc1 = hwdata[trig_pkg::CTRL_CC1_BIT];
          r_next.src = hwdata[trig_pkg::CTRL_SRC_LSB +: 5];
          r_next.tsrc = hwdata[trig_pkg::CTRL_TSRC_LSB +: 5];
        end
        trig_pkg::ADDR_CMD: begin
          r_next.start = hwdata[trig_pkg::CMD_START_BIT];
          r_next.stop = hwdata[trig_pkg::CMD_STOP_BIT];
          r_next.swtrig = hwdata[trig_pkg::CMD_SWTRIG_BIT];
        end
        trig_pkg::ADDR_EXPOSURE: r_next.exposure = hwdata[trig_pkg::TIME_W-1:0];
        trig_pkg::ADDR_PERIOD: r_next.period = hwdata[trig_pkg::TIME_W-1:0];
        trig_pkg::ADDR_TDELAY: r_next.tdelay = hwdata[trig_pkg::TIME_W-1:0];
        default: r_next.wr_pend = 1'b0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '{src: trig_pkg::SRC_SOFTWARE, tsrc: trig_pkg::SRC_HW_LINE, act: 1'b1,
                 exposure: trig_pkg::EXPOSURE_RST, period: trig_pkg::PERIOD_RST,
                 tdelay: trig_pkg::TDELAY_RST, default: '0};
      hreadyout <= 1'b0;
    end else begin
      r_reg <= r_next;
      hreadyout <= 1'b1;
    end
  end

  assign hrdata = r_reg.rdata;
  assign hresp = 1'b0;
  assign link.acq_start = r_reg.start;
  assign link.acq_stop = r_reg.stop;
  assign link.sw_trigger = r_reg.swtrig;
  assign link.trigger_mode = r_reg.mode;
  assign link.trigger_source = r_reg.src;
  assign link.timer_trigger_source = r_reg.tsrc;
  assign link.trigger_activation = r_reg.act;
  assign link.exposure_mode = r_reg.emode;
  assign link.exposure_us = r_reg.exposure;
  assign link.frame_period_us = r_reg.period;
  assign link.timer_delay_us = r_reg.tdelay;
  assign link.host_toggled_output_source = r_reg.host_out;
  assign link.cc1 = r_reg.cc1;
endmodule : trigger_host_ctrl
`default_nettype wire

/* File: verif/trig_link_asserts.sv */
// Concurrent checks on the trigger link between the host end and the camera end.
`default_nettype none
module trig_link_asserts #(
  parameter int READOUT_US = trig_pkg::READOUT_US_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic acq_stop,
  input wire logic sw_trigger,
  input wire logic trigger_mode,
  input wire logic [4:0] trigger_source,
  input wire logic exposure_mode,
  input wire logic [trig_pkg::TIME_W-1:0] exposure_us,
  input wire logic [trig_pkg::TIME_W-1:0] frame_period_us,
  input wire logic acquiring,
  input wire logic waiting,
  input wire logic exposing,
  input wire logic [trig_pkg::FCNT_W-1:0] frame_count
);
  // ****************************************
  // Cycle counters
  // ****************************************
  int exp_reg, gap_reg, rdo_reg, exp_cyc, gap_cyc, rdo_cyc;
  logic armed_reg;
  logic rise;
  // The first cycle of an exposure is the one where the exposure counter is still zero.
  assign rise = exposing && exp_reg == 0;
  always_comb begin
    exp_cyc = int'(exposure_us) * trig_pkg::US_CYCLES;
    if (exposure_us == '0) begin
      exp_cyc = trig_pkg::US_CYCLES;
    end
    rdo_cyc = READOUT_US * trig_pkg::US_CYCLES;
    gap_cyc = int'(frame_period_us) * trig_pkg::US_CYCLES;
    // A clamped trigger is taken in the first waiting cycle after readout.
    if (gap_cyc <= exp_cyc + rdo_cyc) begin
      gap_cyc = exp_cyc + rdo_cyc + 1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_reg <= 0;
      gap_reg <= 0;
      rdo_reg <= 0;
      armed_reg <= 1'b0;
    end else begin
      exp_reg <= exposing ? exp_reg + 1 : 0;
      gap_reg <= rise ? 1 : gap_reg + 1;
      rdo_reg <= (acquiring && !waiting && !exposing) ? rdo_reg + 1 : 0;
      armed_reg <= acquiring && (armed_reg || rise);
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sw_accept_a: assert property (
    trigger_mode && waiting && sw_trigger && trigger_source == trig_pkg::SRC_SOFTWARE
    |=> exposing && !waiting) else $error("software trigger not taken");
  count_step_a: assert property (
    $rose(exposing) |-> frame_count == $past(frame_count) + 16'h0001)
    else $error("frame count did not step with exposure");
  wait_only_a: assert property (
    trigger_mode && $rose(exposing) |-> $past(waiting))
    else $error("exposure started outside waiting");
  mode_hold_a: assert property (
    $past(acquiring) |-> $stable(trigger_mode)) else $error("trigger mode changed in run");
  stop_wait_a: assert property (
    waiting && acq_stop |-> ##[1:2] !acquiring && !waiting)
    else $error("stop while waiting not immediate");
  stop_frame_a: assert property (
    exposing && acq_stop |=> acquiring) else $error("stop cut a frame short");
  free_gap_a: assert property (
    !trigger_mode && armed_reg && rise |-> gap_reg == gap_cyc)
    else $error("free-run frame spacing wrong");
  exp_len_a: assert property (
    !exposure_mode && $fell(exposing) |-> exp_reg == exp_cyc)
    else $error("timed exposure length wrong");
  rdo_len_a: assert property (
    trigger_mode && $rose(waiting) && rdo_reg > 2 |-> rdo_reg == rdo_cyc)
    else $error("return to waiting mistimed");
  cover property (trigger_mode && $rose(exposing));
  cover property (!trigger_mode && armed_reg && rise);
  cover property (exposing && acq_stop);
endmodule : trig_link_asserts
`default_nettype wire

/* File: verif/tb_exposure_start_trigger_ctrl.sv */
// Self-checking bench: host end and camera end joined over the trigger link.
`default_nettype none
module tb_exposure_start_trigger_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RD_US = 2;
  localparam logic [7:0] A_CT = trig_pkg::ADDR_CTRL, A_CM = trig_pkg::ADDR_CMD;
  localparam logic [7:0] A_ST = trig_pkg::ADDR_STATUS;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hardware_trigger_input, frame_start, exposure_active;
  logic [15:0] fc;
  int num_errors, num_checks;
  int starts = 0;
  trig_link_if trig_link_if_i ();
  exposure_start_trigger_ctrl #(.READOUT_US(RD_US)) exposure_start_trigger_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hardware_trigger_input(hardware_trigger_input),
    .frame_start(frame_start), .exposure_active(exposure_active), .link(trig_link_if_i.dev));
  trigger_host_ctrl trigger_host_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(trig_link_if_i.ctl));
  trig_link_asserts #(.READOUT_US(RD_US)) trig_link_asserts_i (
    .hclk(hclk), .hresetn(hresetn), .acq_stop(trig_link_if_i.acq_stop),
    .sw_trigger(trig_link_if_i.sw_trigger), .trigger_mode(trig_link_if_i.trigger_mode),
    .trigger_source(trig_link_if_i.trigger_source),
    .exposure_mode(trig_link_if_i.exposure_mode), .exposure_us(trig_link_if_i.exposure_us),
    .frame_period_us(trig_link_if_i.frame_period_us), .acquiring(trig_link_if_i.acquiring),
    .waiting(trig_link_if_i.waiting), .exposing(trig_link_if_i.exposing),
    .frame_count(trig_link_if_i.frame_count));
  // ****************************************
  // Bus cycles and comparisons
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(what, exp, rd);
    chk("response", 32'h00000000, {31'h00000000, hresp});
  endtask : rchk
  // Status holds the frame count and the acquiring, waiting and exposing flags.
  task automatic stat(input logic [2:0] bits);
    rchk("status", A_ST, {fc, 13'h0000, bits});
    chk("frame starts", {16'h0000, fc}, starts);
    chk("exposure pin", {31'h00000000, bits[2]}, {31'h00000000, exposure_active});
  endtask : stat
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle
  function automatic logic [31:0] ctrl(input logic [4:0] s, input logic act, input logic em,
                                       input logic v);
    ctrl = {11'h000, trig_pkg::SRC_HW_LINE, 3'h0, s, 3'h0, v && s == trig_pkg::SRC_CC1,
            v && s == trig_pkg::SRC_HOST_OUT, em, act, 1'b1};
  endfunction : ctrl
  // The hardware line moves with the selected input and must be ignored when unselected; unselected cc1 and host output stay low.
  task automatic lvl(input logic [4:0] s, input logic act, input logic em, input logic v);
    bus(1'b1, A_CT, ctrl(s, act, em, v));
    hardware_trigger_input <= v;
  endtask : lvl
  task automatic src_test(input logic [4:0] s, input logic act, input logic em, input int w);
    lvl(s, act, em, !act);
    bus(1'b1, A_CM, 32'h00000001);
    idle(20);
    stat(3'b011);
    lvl(s, act, em, act);
    if (s == trig_pkg::SRC_DELAYED) begin
      idle(400);
      stat(3'b011);
    end
    idle(w);
    fc = fc + 16'h0001;
    stat(3'b101);
    idle(900);
    lvl(s, act, em, !act);
    idle(900);
    stat(3'b011);
    bus(1'b1, A_CM, 32'h00000002);
    idle(4);
    stat(3'b000);
  endtask : src_test
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  // ****************************************
  // Clock, watchdog and test sequence
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (frame_start === 1'b1) begin
      starts <= starts + 1;
    end
  end
  initial begin
    repeat (60000) @(posedge hclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    {hresetn, htrans, hwrite, hardware_trigger_input} = '0;
    {haddr, hwdata, fc, num_errors, num_checks} = '0;
    hsel = 1'b1;
    hsize = 3'b010;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("ctrl", A_CT, 32'h00160302);
    rchk("exposure", trig_pkg::ADDR_EXPOSURE, 32'h000003e8);
    rchk("period", trig_pkg::ADDR_PERIOD, 32'h00002710);
    bus(1'b1, 8'h18, 32'hffffffff);
    rchk("unmapped", 8'h18, 32'h00000000);
    stat(3'b000);
    bus(1'b1, trig_pkg::ADDR_EXPOSURE, 32'h00000001);
    bus(1'b1, trig_pkg::ADDR_PERIOD, 32'h00000004);
    bus(1'b1, trig_pkg::ADDR_TDELAY, 32'h00000003);
    bus(1'b1, A_CT, 32'h00160302);
    bus(1'b1, A_CM, 32'h00000001);
    idle(2500);
    fc = fc + 16'h0003;
    stat(3'b001);
    bus(1'b1, A_CT, 32'h00160303);
    rchk("mode frozen", A_CT, 32'h00160302);
    bus(1'b1, A_CM, 32'h00000002);
    idle(1000);
    stat(3'b000);
    bus(1'b1, trig_pkg::ADDR_PERIOD, 32'h00000001);
    bus(1'b1, A_CM, 32'h00000001);
    idle(2000);
    fc = fc + 16'h0003;
    stat(3'b001);
    bus(1'b1, A_CM, 32'h00000002);
    idle(1000);
    stat(3'b000);
    lvl(trig_pkg::SRC_SOFTWARE, 1'b1, 1'b0, 1'b0);
    bus(1'b1, A_CM, 32'h00000001);
    idle(20);
    stat(3'b011);
    bus(1'b1, A_CM, 32'h00000004);
    bus(1'b1, A_CM, 32'h00000004);
    fc = fc + 16'h0001;
    stat(3'b101);
    idle(900);
    stat(3'b011);
    bus(1'b1, A_CM, 32'h00000004);
    idle(50);
    bus(1'b1, A_CM, 32'h00000002);
    fc = fc + 16'h0001;
    stat(3'b101);
    idle(900);
    stat(3'b000);
    src_test(trig_pkg::SRC_HOST_OUT, 1'b1, 1'b0, 100);
    src_test(trig_pkg::SRC_HOST_OUT, 1'b0, 1'b1, 400);
    src_test(trig_pkg::SRC_CC1, 1'b1, 1'b1, 400);
    src_test(trig_pkg::SRC_CC1, 1'b0, 1'b0, 100);
    src_test(trig_pkg::SRC_HW_LINE, 1'b1, 1'b0, 100);
    src_test(trig_pkg::SRC_HW_LINE, 1'b0, 1'b1, 400);
    src_test(trig_pkg::SRC_DELAYED, 1'b1, 1'b0, 450);
    wrap_up();
  end
endmodule : tb_exposure_start_trigger_ctrl
`default_nettype wire
